// ===== include/vad_pkg.sv

`default_nettype none

package vad_pkg;

  // ----------------------------------------------------------------
  // address layout
  // ----------------------------------------------------------------
  localparam int VAD_ADDR_MSB = 23;
  localparam int VAD_ADDR_W = 23;
  localparam int VAD_HIGH_W = 8;
  localparam int VAD_LOW_W = 7;
  localparam int VAD_HIGH_LSB = 16;
  localparam int VAD_LOW_LSB = 9;
  localparam int VAD_OFS_W = 8;

  // ----------------------------------------------------------------
  // modifier codes and enable positions
  // ----------------------------------------------------------------
  localparam int VAD_AM_W = 6;
  localparam logic [5:0] VAD_AM_STD_SUP = 6'h3d;
  localparam logic [5:0] VAD_AM_STD_USR = 6'h39;
  localparam logic [5:0] VAD_AM_SHORT_SUP = 6'h2d;
  localparam logic [5:0] VAD_AM_SHORT_USR = 6'h29;
  localparam logic [5:0] VAD_AM_UNDRIVEN = 6'h3f;
  localparam int VAD_PRI_W = 4;
  localparam int VAD_SEC_W = 2;
  localparam int VAD_PRI_STD_SUP = 0;
  localparam int VAD_PRI_STD_USR = 1;
  localparam int VAD_PRI_SHORT_SUP = 2;
  localparam int VAD_PRI_SHORT_USR = 3;
  localparam int VAD_SEC_IGNORE = 0;
  localparam int VAD_SEC_UNDRIVEN = 1;

  // ----------------------------------------------------------------
  // factory strap patterns (1 = jumper fitted)
  // ----------------------------------------------------------------
  localparam logic [7:0] VAD_DEF_HIGH_FITTED = 8'h4f;
  localparam logic [6:0] VAD_DEF_LOW_FITTED = 7'h6f;
  localparam logic [3:0] VAD_DEF_PRI_FITTED = 4'h0;
  localparam logic [1:0] VAD_DEF_SEC_FITTED = 2'h1;

  // ----------------------------------------------------------------
  // synchroniser input packing
  // ----------------------------------------------------------------
  localparam int VAD_BUS_SYNC_W = 34;
  localparam int VAD_STRAP_SYNC_W = 21;
  localparam logic [VAD_BUS_SYNC_W-1:0] VAD_BUS_IDLE = 34'h3_e000_0000;

  // ----------------------------------------------------------------
  // slave sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    VAD_IDLE = 5'b00001,
    VAD_DEV  = 5'b00010,
    VAD_ACK  = 5'b00100,
    VAD_BERR = 5'b01000,
    VAD_DONE = 5'b10000
  } vad_state_type;

endpackage

`default_nettype wire

// ===== design/vad_pop_table.sv
`timescale 1ns/1ps
`default_nettype none

module vad_pop_table #(
  parameter int SLOTS = 16,
  parameter logic [SLOTS-1:0] POP_MASK = '1
) (
  input wire logic [vad_pkg::VAD_OFS_W-1:0] offset,
  output logic populated
);
  import vad_pkg::*;

  localparam int SLOT_BITS = $clog2(SLOTS);

  generate
    if (SLOTS < 2 || SLOTS > (1 << VAD_OFS_W) || (SLOTS & (SLOTS - 1)) != 0) begin : g_bad_slots
      $error("vad_pop_table: SLOTS must be a power of two from 2 to 256");
    end
  endgenerate

  // ----------------------------------------------------------------
  // one match line per slot of the window
  // ----------------------------------------------------------------
  logic [SLOTS-1:0] slot_hit;
  logic [SLOT_BITS-1:0] slot_idx;

  assign slot_idx = offset[VAD_OFS_W-1 -: SLOT_BITS];

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      assign slot_hit[g] = POP_MASK[g] && (slot_idx == SLOT_BITS'(g));
    end
  endgenerate

  assign populated = |slot_hit;

endmodule

`default_nettype wire

// ===== design/vad_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module vad_decoder #(
  parameter int POP_SLOTS = 16,
  parameter logic [POP_SLOTS-1:0] POP_MASK = 16'h00ff
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // bus side pins, asynchronous to ref_clk
  input wire logic [vad_pkg::VAD_ADDR_MSB:1] vme_addr,
  input wire logic [vad_pkg::VAD_AM_W-1:0] vme_am,
  input wire logic vme_as_n,
  input wire logic vme_ds0_n,
  input wire logic vme_ds1_n,
  input wire logic vme_write_n,
  input wire logic vme_iack_n,
  output logic vme_dtack_o,
  output logic vme_dtack_oe_n,
  output logic vme_berr_o,
  output logic vme_berr_oe_n,
  // straps, 1 = jumper fitted
  input wire logic [vad_pkg::VAD_HIGH_W-1:0] base_high_strap_field,
  input wire logic [vad_pkg::VAD_LOW_W-1:0] base_low_strap_field,
  input wire logic [vad_pkg::VAD_PRI_W-1:0] modifier_enable_field_primary,
  input wire logic [vad_pkg::VAD_SEC_W-1:0] modifier_enable_field_secondary,
  // local device side, same clock
  output logic dev_req,
  output logic [vad_pkg::VAD_OFS_W-1:0] dev_offset,
  output logic dev_write,
  input wire logic dev_ack,
  // status
  output logic sel_active,
  output logic short_mode,
  output logic am_cfg_error
);
  import vad_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the slot index is cut from the top of the window offset, so the
  // slot count must be a power of two that the offset can address
  generate
    if (POP_SLOTS < 2 || POP_SLOTS > (1 << VAD_OFS_W)) begin : g_slots_range
      $error("vad_decoder: POP_SLOTS out of range");
    end
    if ((POP_SLOTS & (POP_SLOTS - 1)) != 0) begin : g_slots_pow2
      $error("vad_decoder: POP_SLOTS must be a power of two");
    end
  endgenerate

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // every bus pin passes two flops; straps too, since a jumper may be
  // moved while powered and must not glitch the compare
  // clk_en low holds both stages, so a frozen block never sees half of
  // a bus cycle when it wakes
  logic [VAD_BUS_SYNC_W-1:0] bus_meta_r, bus_meta_nxt;
  logic [VAD_BUS_SYNC_W-1:0] bus_sync_r, bus_sync_nxt;
  logic [VAD_STRAP_SYNC_W-1:0] strap_meta_r, strap_meta_nxt;
  logic [VAD_STRAP_SYNC_W-1:0] strap_sync_r, strap_sync_nxt;

  always_comb begin
    bus_meta_nxt = bus_meta_r;
    bus_sync_nxt = bus_sync_r;
    strap_meta_nxt = strap_meta_r;
    strap_sync_nxt = strap_sync_r;
    if (clk_en) begin
      bus_meta_nxt = {vme_iack_n, vme_write_n, vme_ds1_n, vme_ds0_n,
                      vme_as_n, vme_am, vme_addr};
      bus_sync_nxt = bus_meta_r;
      strap_meta_nxt = {modifier_enable_field_secondary,
                        modifier_enable_field_primary,
                        base_low_strap_field, base_high_strap_field};
      strap_sync_nxt = strap_meta_r;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_meta_r <= VAD_BUS_IDLE;
      bus_sync_r <= VAD_BUS_IDLE;
      strap_meta_r <= {VAD_DEF_SEC_FITTED, VAD_DEF_PRI_FITTED,
                       VAD_DEF_LOW_FITTED, VAD_DEF_HIGH_FITTED};
      strap_sync_r <= {VAD_DEF_SEC_FITTED, VAD_DEF_PRI_FITTED,
                       VAD_DEF_LOW_FITTED, VAD_DEF_HIGH_FITTED};
    end else begin
      bus_meta_r <= bus_meta_nxt;
      bus_sync_r <= bus_sync_nxt;
      strap_meta_r <= strap_meta_nxt;
      strap_sync_r <= strap_sync_nxt;
    end
  end

  // ----------------------------------------------------------------
  // unpack synchronised fields
  // ----------------------------------------------------------------
  logic [VAD_ADDR_MSB:1] s_addr;
  logic [VAD_AM_W-1:0] s_am;
  logic s_as_n;
  logic s_ds0_n;
  logic s_ds1_n;
  logic s_write_n;
  logic s_iack_n;
  logic [VAD_HIGH_W-1:0] s_high_fit;
  logic [VAD_LOW_W-1:0] s_low_fit;
  logic [VAD_PRI_W-1:0] s_pri_fit;
  logic [VAD_SEC_W-1:0] s_sec_fit;

  assign {s_iack_n, s_write_n, s_ds1_n, s_ds0_n, s_as_n, s_am, s_addr} = bus_sync_r;
  assign {s_sec_fit, s_pri_fit, s_low_fit, s_high_fit} = strap_sync_r;

  // ----------------------------------------------------------------
  // base address compare
  // ----------------------------------------------------------------
  logic [VAD_HIGH_W-1:0] exp_high;
  logic [VAD_LOW_W-1:0] exp_low;
  logic high_match;
  logic low_match;

  assign exp_high = ~s_high_fit;
  assign exp_low = ~s_low_fit;
  // high field covers A23..A16, low field A15..A9
  assign high_match = (s_addr[VAD_ADDR_MSB:VAD_HIGH_LSB] == exp_high);
  assign low_match = (s_addr[VAD_HIGH_LSB-1:VAD_LOW_LSB] == exp_low);

  // ----------------------------------------------------------------
  // modifier classification
  // ----------------------------------------------------------------
  logic am_std_ok;
  logic am_short_ok;
  logic cfg_ok;
  logic addr_hit;

  always_comb begin
    am_std_ok = 1'b0;
    am_short_ok = 1'b0;
    if (s_pri_fit[VAD_PRI_STD_SUP] && s_am == VAD_AM_STD_SUP) begin
      am_std_ok = 1'b1;
    end
    if (s_pri_fit[VAD_PRI_STD_USR] && s_am == VAD_AM_STD_USR) begin
      am_std_ok = 1'b1;
    end
    // 3f is taken as a plain standard access, never as block transfer
    if (s_sec_fit[VAD_SEC_UNDRIVEN] && s_am == VAD_AM_UNDRIVEN) begin
      am_std_ok = 1'b1;
    end
    if (s_sec_fit[VAD_SEC_IGNORE]) begin
      am_std_ok = 1'b1;
    end
    if (s_pri_fit[VAD_PRI_SHORT_SUP] && s_am == VAD_AM_SHORT_SUP) begin
      am_short_ok = 1'b1;
    end
    if (s_pri_fit[VAD_PRI_SHORT_USR] && s_am == VAD_AM_SHORT_USR) begin
      am_short_ok = 1'b1;
    end
  end

  // with no enable fitted the board stays silent rather than guessing
  assign cfg_ok = |{s_sec_fit, s_pri_fit};

  // a short code that is enabled wins over ignore-mode, so a short access
  // never depends on the high straps
  assign addr_hit = cfg_ok && low_match &&
                    (am_short_ok || (am_std_ok && high_match));

  // ----------------------------------------------------------------
  // populated slot lookup
  // ----------------------------------------------------------------
  // A0 and the byte lanes are not decoded: any byte of a populated slot
  // is claimed, so software must keep to the device's own registers
  logic slot_populated;

  vad_pop_table #(
    .SLOTS(POP_SLOTS),
    .POP_MASK(POP_MASK)
  ) u_pop (
    .offset(s_addr[VAD_LOW_LSB-1:1]),
    .populated(slot_populated)
  );

  // ----------------------------------------------------------------
  // slave sequencer
  // ----------------------------------------------------------------
  logic strobe;
  vad_state_type state_r, state_nxt;
  logic dev_req_r, dev_req_nxt;
  logic [VAD_OFS_W-1:0] dev_offset_r, dev_offset_nxt;
  logic dev_write_r, dev_write_nxt;
  logic dtack_r, dtack_nxt;
  logic berr_r, berr_nxt;
  logic short_r, short_nxt;

  // interrupt acknowledge cycles are not data transfers and never select
  assign strobe = !s_as_n && (!s_ds0_n || !s_ds1_n) && s_iack_n;

  always_comb begin
    state_nxt = state_r;
    dev_req_nxt = dev_req_r;
    dev_offset_nxt = dev_offset_r;
    dev_write_nxt = dev_write_r;
    dtack_nxt = dtack_r;
    berr_nxt = berr_r;
    short_nxt = short_r;
    if (clk_en) begin
      case (state_r)
        VAD_IDLE: begin
          if (strobe && addr_hit) begin
            // latch offset and direction so the device sees a steady request
            dev_offset_nxt = s_addr[VAD_LOW_LSB-1:1];
            dev_write_nxt = !s_write_n;
            short_nxt = am_short_ok;
            if (slot_populated) begin
              dev_req_nxt = 1'b1;
              state_nxt = VAD_DEV;
            end else begin
              berr_nxt = 1'b1;
              state_nxt = VAD_BERR;
            end
          end
        end
        VAD_DEV: begin
          // dev_ack shares ref_clk and is read without a synchroniser
          if (!strobe) begin
            // master gave up; drop the request without answering
            dev_req_nxt = 1'b0;
            state_nxt = VAD_IDLE;
          end else if (dev_ack) begin
            dev_req_nxt = 1'b0;
            dtack_nxt = 1'b1;
            state_nxt = VAD_ACK;
          end
        end
        VAD_ACK: begin
          // hold the acknowledge until the data strobes are released
          if (!strobe) begin
            dtack_nxt = 1'b0;
            state_nxt = VAD_DONE;
          end
        end
        VAD_BERR: begin
          if (!strobe) begin
            berr_nxt = 1'b0;
            state_nxt = VAD_DONE;
          end
        end
        VAD_DONE: begin
          // one idle cycle so a stale strobe sample cannot reselect
          state_nxt = VAD_IDLE;
        end
        default: begin
          dev_req_nxt = 1'b0;
          dtack_nxt = 1'b0;
          berr_nxt = 1'b0;
          state_nxt = VAD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= VAD_IDLE;
      dev_req_r <= 1'b0;
      dev_offset_r <= '0;
      dev_write_r <= 1'b0;
      dtack_r <= 1'b0;
      berr_r <= 1'b0;
      short_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dev_req_r <= dev_req_nxt;
      dev_offset_r <= dev_offset_nxt;
      dev_write_r <= dev_write_nxt;
      dtack_r <= dtack_nxt;
      berr_r <= berr_nxt;
      short_r <= short_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain lines: the level is always low, the enable says when
  assign vme_dtack_o = 1'b0;
  assign vme_dtack_oe_n = !dtack_r;
  assign vme_berr_o = 1'b0;
  assign vme_berr_oe_n = !berr_r;
  assign dev_req = dev_req_r;
  assign dev_offset = dev_offset_r;
  assign dev_write = dev_write_r;
  // any state but idle means the board owns the current cycle
  assign sel_active = (state_r != VAD_IDLE);
  assign short_mode = short_r;
  assign am_cfg_error = !cfg_ok;

endmodule

`default_nettype wire

// ===== bench/vad_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module vad_decoder_monitor #(
  parameter logic [15:0] POP_MASK = 16'h00ff
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [23:1] vme_addr,
  input wire logic [5:0] vme_am,
  input wire logic vme_as_n,
  input wire logic vme_write_n,
  input wire logic vme_dtack_oe_n,
  input wire logic vme_berr_oe_n,
  input wire logic [7:0] base_high_strap_field,
  input wire logic [6:0] base_low_strap_field,
  input wire logic [3:0] modifier_enable_field_primary,
  input wire logic [1:0] modifier_enable_field_secondary,
  input wire logic dev_req,
  input wire logic [7:0] dev_offset,
  input wire logic dev_write,
  input wire logic dev_ack,
  input wire logic short_mode,
  input wire logic am_cfg_error
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------
  // answers
  // --------------------------------------------------------------
  answer_excl_a: assert property (!(!vme_dtack_oe_n && !vme_berr_oe_n))
    else $error("dtack and berr driven together");
  dtack_cause_a: assert property ($fell(vme_dtack_oe_n) |-> $past(dev_req && dev_ack))
    else $error("dtack without a served request");
  berr_cause_a: assert property ($fell(vme_berr_oe_n) |-> $past(!vme_as_n, 2) &&
    !POP_MASK[$past(vme_addr[8:5], 2)])
    else $error("berr without strobe or on populated slot");
  answer_release_a: assert property ($rose(vme_as_n) |->
    ##[1:5] (vme_dtack_oe_n && vme_berr_oe_n))
    else $error("answer held after strobe release");
  // --------------------------------------------------------------
  // decoding
  // --------------------------------------------------------------
  window_low_a: assert property (
    ($rose(dev_req) || $fell(vme_berr_oe_n)) |->
    $past(vme_addr[15:9], 2) == ~$past(base_low_strap_field, 2))
    else $error("select outside low strap window");
  window_high_a: assert property ($rose(dev_req) && !short_mode |->
    $past(vme_addr[23:16], 2) == ~$past(base_high_strap_field, 2))
    else $error("standard select outside high strap window");
  short_code_a: assert property ($rose(dev_req) && short_mode |->
    $past(vme_am, 2) inside {6'h2d, 6'h29})
    else $error("short decode without short code");
  offset_pass_a: assert property ($rose(dev_req) |->
    dev_offset == $past(vme_addr[8:1], 2) && dev_write == !$past(vme_write_n, 2))
    else $error("device offset or direction wrong");
  cfg_error_a: assert property (($stable(modifier_enable_field_primary) &&
    $stable(modifier_enable_field_secondary))[*3] |-> am_cfg_error ==
    (modifier_enable_field_primary == 4'h0 && modifier_enable_field_secondary == 2'h0))
    else $error("modifier config error flag wrong");

  cover property ($fell(vme_dtack_oe_n));
  cover property ($fell(vme_berr_oe_n));
  cover property ($rose(dev_req) && short_mode);
endmodule

bind vad_decoder vad_decoder_monitor #(.POP_MASK(POP_MASK)) vad_decoder_monitor_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .vme_addr(vme_addr), .vme_am(vme_am),
  .vme_as_n(vme_as_n), .vme_write_n(vme_write_n), .vme_dtack_oe_n(vme_dtack_oe_n),
  .vme_berr_oe_n(vme_berr_oe_n), .base_high_strap_field(base_high_strap_field),
  .base_low_strap_field(base_low_strap_field),
  .modifier_enable_field_primary(modifier_enable_field_primary),
  .modifier_enable_field_secondary(modifier_enable_field_secondary),
  .dev_req(dev_req), .dev_offset(dev_offset), .dev_write(dev_write), .dev_ack(dev_ack),
  .short_mode(short_mode), .am_cfg_error(am_cfg_error)
);

`default_nettype wire

// ===== bench/vad_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module vad_master_model (
  input wire logic ref_clk,
  output logic [23:1] vme_addr,
  output logic [5:0] vme_am,
  output logic vme_as_n,
  output logic vme_ds0_n,
  output logic vme_ds1_n,
  output logic vme_write_n,
  output logic vme_iack_n,
  input wire logic vme_dtack_oe_n,
  input wire logic vme_berr_oe_n
);
  // released lines float up to the terminator level
  task automatic bus_idle();
    vme_addr = '1;
    vme_am = '1;
    vme_as_n = 1'b1;
    vme_ds0_n = 1'b1;
    vme_ds1_n = 1'b1;
    vme_write_n = 1'b1;
    vme_iack_n = 1'b1;
  endtask

  initial bus_idle();

  // resp: bit0 dtack, bit1 berr, 0 = no slave answered within the bus time
  task automatic access(input logic [23:1] a, input logic [5:0] am, input logic wr,
      input logic iack, output logic [1:0] resp);
    int n;
    @(negedge ref_clk);
    vme_addr = a;
    vme_am = am;
    vme_write_n = !wr;
    vme_iack_n = !iack;
    vme_as_n = 1'b0;
    vme_ds0_n = 1'b0;
    vme_ds1_n = 1'b0;
    resp = 2'h0;
    n = 0;
    while (resp == 2'h0 && n < 16) begin
      @(posedge ref_clk);
      resp = {!vme_berr_oe_n, !vme_dtack_oe_n};
      n++;
    end
    @(negedge ref_clk);
    bus_idle();
    // slave needs a few edges to see the release and let go
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

// ===== bench/vad_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none

module vad_decoder_bench;
  import vad_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic dev_ack = 1'b0;
  logic clk_en = 1'b1;
  logic dev_hold = 1'b0;
  logic seen_sel;
  logic [7:0] hi_strap = VAD_DEF_HIGH_FITTED;
  logic [6:0] lo_strap = VAD_DEF_LOW_FITTED;
  logic [3:0] pri_en = VAD_DEF_PRI_FITTED;
  logic [1:0] sec_en = VAD_DEF_SEC_FITTED;
  logic [23:1] vme_addr;
  logic [5:0] vme_am;
  logic as_n, ds0_n, ds1_n, write_n, iack_n, dtack_o, dtack_oe_n, berr_o, berr_oe_n;
  logic dev_req, dev_write, sel_active, short_mode, am_cfg_error, seen_short, seen_wr;
  logic [7:0] dev_offset, seen_off;
  logic [1:0] resp;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #10 ref_clk = ~ref_clk;
  // local device answers at once unless held off
  always @(negedge ref_clk) dev_ack <= dev_req && !dev_hold;
  always @(posedge ref_clk) if (dev_req) begin
    seen_off <= dev_offset;
    seen_sel <= sel_active;
    seen_short <= short_mode;
    seen_wr <= dev_write;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  vad_master_model vad_master_model_inst (.ref_clk(ref_clk), .vme_addr(vme_addr),
    .vme_am(vme_am), .vme_as_n(as_n), .vme_ds0_n(ds0_n), .vme_ds1_n(ds1_n),
    .vme_write_n(write_n), .vme_iack_n(iack_n), .vme_dtack_oe_n(dtack_oe_n),
    .vme_berr_oe_n(berr_oe_n));
  vad_decoder vad_decoder_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .vme_addr(vme_addr), .vme_am(vme_am), .vme_as_n(as_n), .vme_ds0_n(ds0_n),
    .vme_ds1_n(ds1_n), .vme_write_n(write_n), .vme_iack_n(iack_n), .vme_dtack_o(dtack_o),
    .vme_dtack_oe_n(dtack_oe_n), .vme_berr_o(berr_o), .vme_berr_oe_n(berr_oe_n),
    .base_high_strap_field(hi_strap), .base_low_strap_field(lo_strap),
    .modifier_enable_field_primary(pri_en), .modifier_enable_field_secondary(sec_en),
    .dev_req(dev_req), .dev_offset(dev_offset), .dev_write(dev_write), .dev_ack(dev_ack),
    .sel_active(sel_active), .short_mode(short_mode), .am_cfg_error(am_cfg_error));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // exp: 1 dtack, 2 berr, 0 ignored
  task automatic go(input string what, input logic [23:0] a, input logic [5:0] am,
      input logic wr, input logic [1:0] exp);
    vad_master_model_inst.access(a[23:1], am, wr, 1'b0, resp);
    chk(what, {6'h0, exp}, {6'h0, resp});
  endtask

  // straps pass a two-flop synchroniser, so let them settle
  task automatic strap(input logic [7:0] h, input logic [6:0] l, input logic [3:0] p,
      input logic [1:0] s);
    @(negedge ref_clk);
    hi_strap = h;
    lo_strap = l;
    pri_en = p;
    sec_en = s;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic t_default();
    go("default base", 24'hb02000, 6'h05, 1'b0, 2'h1);
    go("last populated", 24'hb020fe, 6'h0d, 1'b1, 2'h1);
    chk("offset", 8'h7f, seen_off);
    chk("write", 8'h01, {7'h0, seen_wr});
    chk("selected", 8'h01, {7'h0, seen_sel});
    chk("drive level", 8'h00, {6'h0, dtack_o, berr_o});
    go("unpopulated", 24'hb021fe, 6'h3e, 1'b0, 2'h2);
    go("next window", 24'hb02200, 6'h3d, 1'b0, 2'h0);
    go("below window", 24'hb01e00, 6'h3d, 1'b0, 2'h0);
  endtask

  task automatic t_std();
    logic [5:0] codes [5] = '{6'h3d, 6'h39, 6'h2d, 6'h29, 6'h3f};
    logic [1:0] want [5] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
    strap(8'h5a, 7'h45, 4'h3, 2'h0);
    for (int i = 0; i < 5; i++) begin
      go("std code", 24'ha57400, codes[i], 1'b0, want[i]);
    end
    go("high miss", 24'h257400, 6'h3d, 1'b0, 2'h0);
    go("low miss", 24'ha57600, 6'h39, 1'b0, 2'h0);
    strap(8'h5a, 7'h45, 4'h0, 2'h2);
    go("undriven code", 24'ha57400, 6'h3f, 1'b0, 2'h1);
    go("undriven high miss", 24'h257400, 6'h3f, 1'b0, 2'h0);
    go("not enabled", 24'ha57400, 6'h3d, 1'b0, 2'h0);
  endtask

  task automatic t_short();
    strap(8'h00, 7'h74, 4'h8, 2'h0);
    go("short hit", 24'h3c1600, 6'h29, 1'b1, 2'h1);
    chk("short mode", 8'h01, {7'h0, seen_short});
    go("short off code", 24'h3c1600, 6'h2d, 1'b0, 2'h0);
    go("short miss", 24'h3c1800, 6'h29, 1'b0, 2'h0);
    strap(8'h00, 7'h74, 4'hc, 2'h1);
    go("short with ignore", 24'h771600, 6'h2d, 1'b0, 2'h1);
    go("full decode miss", 24'h771600, 6'h3d, 1'b0, 2'h0);
    go("full decode hit", 24'hff1600, 6'h3d, 1'b0, 2'h1);
    chk("std mode", 8'h00, {7'h0, seen_short});
    vad_master_model_inst.access(23'h7f8b00, 6'h3d, 1'b0, 1'b1, resp);
    chk("iack cycle", 8'h00, {6'h0, resp});
    strap(8'h00, 7'h74, 4'h0, 2'h0);
    chk("cfg error", 8'h01, {7'h0, am_cfg_error});
    go("no enable", 24'h3c1600, 6'h29, 1'b0, 2'h0);
  endtask

  // clock enable freeze, then a device that never answers
  task automatic t_stall();
    @(negedge ref_clk);
    clk_en = 1'b0;
    go("frozen", 24'hb02000, 6'h3d, 1'b0, 2'h0);
    @(negedge ref_clk);
    clk_en = 1'b1;
    go("thawed", 24'hb02000, 6'h3d, 1'b0, 2'h1);
    dev_hold = 1'b1;
    go("device silent", 24'hb02000, 6'h3d, 1'b0, 2'h0);
    chk("request dropped", 8'h00, {6'h0, dev_req, sel_active});
    dev_hold = 1'b0;
  endtask

  // reset in mid-run clears the captured state, then decoding resumes
  task automatic t_reset();
    strap(8'h00, 7'h74, 4'h8, 2'h0);
    go("pre reset", 24'h3c1600, 6'h29, 1'b0, 2'h1);
    chk("short held", 8'h01, {7'h0, short_mode});
    @(negedge ref_clk);
    sys_rst = 1'b1;
    @(negedge ref_clk);
    chk("reset hold", 8'h03, {6'h0, dtack_oe_n, berr_oe_n});
    chk("reset state", 8'h00, {4'h0, dev_req, sel_active, short_mode, am_cfg_error});
    sys_rst = 1'b0;
    go("after reset", 24'h3c1600, 6'h29, 1'b0, 2'h1);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_default();
    t_stall();
    t_std();
    t_short();
    t_reset();
    end_sim();
  end
endmodule

`default_nettype wire
